// ---- rdad_decoder.sv ----
// Processor address decoder with reset default map, plus the
// programmable PCI-side and VME-inbound window decoders and VME-outbound offset translation.
// Assumes address strobes and programming ports come from core_clk logic.
//
// Behaviour
// - Default map applies after reset until software reprograms it.
// - Listed gap ranges of the default map select no target.
// - 0x80000000-0x8001FFFF goes to PCI/ISA I/O space.
// - 0xFEF80000-0xFEF8FFFF goes to memory-controller registers.
// - 0xFEFF0000-0xFEFFFFFF goes to bridge registers.
// - Swap clear: top 1 MB maps to first 1 MB of bank A.
// - Swap set: top 1 MB maps to bank B instead.
// - Reset switches all PCI map decoders off.
// - VME inbound decoder is programmable, no fixed mapping.
// - Outbound translation lets processor reach any VME address.
`timescale 1ns/1ns
module rdad_decoder (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Processor address cycle
  input  wire logic        cpuValid,
  input  wire logic [31:0] cpuAddr,
  // Boot bank steering
  input  wire logic        boot_bank_swap,
  // Processor map reprogramming
  input  wire logic        mapProgram,
  input  wire logic        mapLoad,
  input  wire logic [3:0]  mapTarget,
  input  wire logic [31:0] mapBase,
  input  wire logic [31:0] mapMask,
  // PCI-side decoder programming and lookup
  input  wire logic        pciWrEn,
  input  wire logic [1:0]  pciWrIdx,
  input  wire logic [31:0] pciWrBase,
  input  wire logic [31:0] pciWrMask,
  input  wire logic [31:0] pciWrOffset,
  input  wire logic        pciWrEnable,
  input  wire logic        pciValid,
  input  wire logic [31:0] pciAddr,
  // VME inbound decoder programming and lookup
  input  wire logic        vmeInWrEn,
  input  wire logic [1:0]  vmeInWrIdx,
  input  wire logic [31:0] vmeInWrBase,
  input  wire logic [31:0] vmeInWrMask,
  input  wire logic [31:0] vmeInWrOffset,
  input  wire logic        vmeInWrEnable,
  input  wire logic        vmeInValid,
  input  wire logic [31:0] vmeInAddr,
  // VME outbound translation
  input  wire logic        vmeOutWrEn,
  input  wire logic [31:0] vmeOutWrOffset,
  input  wire logic        vmeOutValid,
  input  wire logic [31:0] vmeOutAddr,
  // Processor decode results
  output logic [3:0]       tgtSel,
  output logic             bootBankB,
  output logic [31:0]      tgtOffset,
  output logic             cpuUnmapped,
  output logic             mapDefault,
  // PCI decode results
  output logic [3:0]       pciHit,
  output logic [31:0]      pciLocalAddr,
  // VME inbound decode results
  output logic [3:0]       vmeInHit,
  output logic [31:0]      vmeInLocalAddr,
  // VME outbound result
  output logic             vmeOutValidQ,
  output logic [31:0]      vmeOutBusAddr
);

  // ==========================================================
  // Helpers
  function automatic logic inRange(input logic [31:0] a,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  function automatic logic [3:0] winHits(input logic [31:0]  a,
                                         input logic [127:0] b,
                                         input logic [127:0] m,
                                         input logic [3:0]   en);
    winHits = 4'h0;
    for (int i = 0; i < rdad_pkg::NUM_WIN; i++) begin
      winHits[i] = en[i] && ((a & m[32*i +: 32]) == b[32*i +: 32]);
    end
  endfunction : winHits

  function automatic logic [31:0] winXlate(input logic [31:0]  a,
                                           input logic [3:0]   h,
                                           input logic [127:0] o);
    winXlate = 32'h0000_0000;
    // Lowest window wins when windows overlap
    for (int i = rdad_pkg::NUM_WIN - 1; i >= 0; i--) begin
      if (h[i]) winXlate = a + o[32*i +: 32];
    end
  endfunction : winXlate

  // ==========================================================
  // Processor map mode
  logic        progMode;
  logic [3:0]  progTarget;
  logic [31:0] progBase;
  logic [31:0] progMask;
  logic        next_progMode;
  logic [3:0]  next_progTarget;
  logic [31:0] next_progBase;
  logic [31:0] next_progMask;

  always_comb begin
    next_progMode   = progMode;
    next_progTarget = progTarget;
    next_progBase   = progBase;
    next_progMask   = progMask;
    if (mapLoad) begin
      next_progTarget = mapTarget;
      next_progBase   = mapBase;
      next_progMask   = mapMask;
    end
    if (mapProgram) next_progMode = 1'b1;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      progMode   <= 1'b0;
      progTarget <= rdad_pkg::TGT_NONE;
      progBase   <= rdad_pkg::WIN_RST_VAL;
      progMask   <= rdad_pkg::WIN_RST_VAL;
    end else begin
      progMode   <= next_progMode;
      progTarget <= next_progTarget;
      progBase   <= next_progBase;
      progMask   <= next_progMask;
    end
  end

  // ==========================================================
  // Processor decode
  logic [3:0]  next_tgtSel;
  logic        next_bootBankB;
  logic [31:0] next_tgtOffset;
  logic        next_cpuUnmapped;

  always_comb begin
    next_tgtSel      = rdad_pkg::TGT_NONE;
    next_bootBankB   = 1'b0;
    next_tgtOffset   = 32'h0000_0000;
    next_cpuUnmapped = 1'b0;
    if (cpuValid) begin
      if (progMode) begin
        if ((cpuAddr & progMask) == progBase) begin
          next_tgtSel    = progTarget;
          next_tgtOffset = cpuAddr & ~progMask;
        end
      end else if (inRange(cpuAddr, rdad_pkg::PCIIO_BASE,
                           rdad_pkg::PCIIO_LAST)) begin
        next_tgtSel    = rdad_pkg::TGT_PCIIO;
        next_tgtOffset = cpuAddr - rdad_pkg::PCIIO_BASE;
      end else if (inRange(cpuAddr, rdad_pkg::MCREG_BASE,
                           rdad_pkg::MCREG_LAST)) begin
        next_tgtSel    = rdad_pkg::TGT_MCREG;
        next_tgtOffset = cpuAddr - rdad_pkg::MCREG_BASE;
      end else if (inRange(cpuAddr, rdad_pkg::BRREG_BASE,
                           rdad_pkg::BRREG_LAST)) begin
        next_tgtSel    = rdad_pkg::TGT_BRREG;
        next_tgtOffset = cpuAddr - rdad_pkg::BRREG_BASE;
      end else if (inRange(cpuAddr, rdad_pkg::BOOT_BASE,
                           rdad_pkg::BOOT_LAST)) begin
        next_tgtSel    = rdad_pkg::TGT_BOOT;
        next_bootBankB = boot_bank_swap;
        next_tgtOffset = {12'h000, cpuAddr[rdad_pkg::BOOT_OFS_W-1:0]};
      end
    end
    if (cpuValid && (next_tgtSel == rdad_pkg::TGT_NONE)) begin
      next_cpuUnmapped = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tgtSel      <= rdad_pkg::TGT_NONE;
      bootBankB   <= 1'b0;
      tgtOffset   <= 32'h0000_0000;
      cpuUnmapped <= 1'b0;
      mapDefault  <= 1'b1;
    end else begin
      tgtSel      <= next_tgtSel;
      bootBankB   <= next_bootBankB;
      tgtOffset   <= next_tgtOffset;
      cpuUnmapped <= next_cpuUnmapped;
      mapDefault  <= ~next_progMode;
    end
  end

  // ==========================================================
  // PCI and VME inbound window tables
  logic [127:0] pciB, pciM, pciO;
  logic [3:0]   pciE;
  logic [127:0] vinB, vinM, vinO;
  logic [3:0]   vinE;

  // Table resets with all windows off
  rdad_win_table uPciWin (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wrEn     (pciWrEn),
    .wrIdx    (pciWrIdx),
    .wrBase   (pciWrBase),
    .wrMask   (pciWrMask),
    .wrOffset (pciWrOffset),
    .wrEnable (pciWrEnable),
    .rdBase   (pciB),
    .rdMask   (pciM),
    .rdOffset (pciO),
    .rdEnable (pciE)
  );

  rdad_win_table uVmeWin (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wrEn     (vmeInWrEn),
    .wrIdx    (vmeInWrIdx),
    .wrBase   (vmeInWrBase),
    .wrMask   (vmeInWrMask),
    .wrOffset (vmeInWrOffset),
    .wrEnable (vmeInWrEnable),
    .rdBase   (vinB),
    .rdMask   (vinM),
    .rdOffset (vinO),
    .rdEnable (vinE)
  );

  // ==========================================================
  // Lookups and outbound translation
  logic [3:0]  next_pciHit, next_vmeInHit;
  logic [31:0] next_pciLocal, next_vmeInLocal, vmeOutOfs, next_vmeOutOfs;
  logic [31:0] next_vmeOutBus;

  always_comb begin
    next_pciHit     = pciValid ? winHits(pciAddr, pciB, pciM, pciE) : 4'h0;
    next_pciLocal   = winXlate(pciAddr, next_pciHit, pciO);
    next_vmeInHit   = vmeInValid ?
                      winHits(vmeInAddr, vinB, vinM, vinE) : 4'h0;
    next_vmeInLocal = winXlate(vmeInAddr, next_vmeInHit, vinO);
    next_vmeOutOfs  = vmeOutWrEn ? vmeOutWrOffset : vmeOutOfs;
    // Full 32-bit wrapping offset reaches any VME address
    next_vmeOutBus  = vmeOutValid ? vmeOutAddr + vmeOutOfs : vmeOutBusAddr;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pciHit         <= 4'h0;
      pciLocalAddr   <= 32'h0000_0000;
      vmeInHit       <= 4'h0;
      vmeInLocalAddr <= 32'h0000_0000;
      vmeOutOfs      <= 32'h0000_0000;
      vmeOutValidQ   <= 1'b0;
      vmeOutBusAddr  <= 32'h0000_0000;
    end else begin
      pciHit         <= next_pciHit;
      pciLocalAddr   <= next_pciLocal;
      vmeInHit       <= next_vmeInHit;
      vmeInLocalAddr <= next_vmeInLocal;
      vmeOutOfs      <= next_vmeOutOfs;
      vmeOutValidQ   <= vmeOutValid;
      vmeOutBusAddr  <= next_vmeOutBus;
    end
  end

endmodule : rdad_decoder

// ---- rdad_pkg.sv ----
// Package for the reset default address decoder.
// Assumes a 32-bit processor address and a single core clock domain.
package rdad_pkg;

  // ==========================================================
  // Default processor map windows
  localparam logic [31:0] PCIIO_BASE  = 32'h8000_0000;
  localparam logic [31:0] PCIIO_LAST  = 32'h8001_FFFF;
  localparam logic [31:0] MCREG_BASE  = 32'hFEF8_0000;
  localparam logic [31:0] MCREG_LAST  = 32'hFEF8_FFFF;
  localparam logic [31:0] BRREG_BASE  = 32'hFEFF_0000;
  localparam logic [31:0] BRREG_LAST  = 32'hFEFF_FFFF;
  localparam logic [31:0] BOOT_BASE   = 32'hFFF0_0000;
  localparam logic [31:0] BOOT_LAST   = 32'hFFFF_FFFF;
  localparam int          BOOT_OFS_W  = 20;

  // ==========================================================
  // Programmable decoder windows
  localparam int          NUM_WIN     = 4;
  localparam int          WIN_IDX_W   = 2;
  localparam logic [31:0] WIN_RST_VAL = 32'h0000_0000;

  // ==========================================================
  // Target select encoding, one-hot
  localparam int         TGT_W     = 4;
  localparam logic [3:0] TGT_NONE  = 4'h0;
  localparam logic [3:0] TGT_PCIIO = 4'h1;
  localparam logic [3:0] TGT_MCREG = 4'h2;
  localparam logic [3:0] TGT_BRREG = 4'h4;
  localparam logic [3:0] TGT_BOOT  = 4'h8;

endpackage : rdad_pkg

// ---- rdad_win_table.sv ----
// Small table of programmable address windows (base, mask, offset).
// Assumes writes come from logic on core_clk; read data is registered.
`timescale 1ns/1ns
module rdad_win_table (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Write port
  input  wire logic        wrEn,
  input  wire logic [1:0]  wrIdx,
  input  wire logic [31:0] wrBase,
  input  wire logic [31:0] wrMask,
  input  wire logic [31:0] wrOffset,
  input  wire logic        wrEnable,
  // Registered read port, all windows at once
  output logic [127:0]     rdBase,
  output logic [127:0]     rdMask,
  output logic [127:0]     rdOffset,
  output logic [3:0]       rdEnable
);

  // ==========================================================
  // Storage
  logic [31:0] base   [rdad_pkg::NUM_WIN];
  logic [31:0] mask   [rdad_pkg::NUM_WIN];
  logic [31:0] offset [rdad_pkg::NUM_WIN];
  logic [3:0]  enable;

  genvar g;
  generate
    for (g = 0; g < rdad_pkg::NUM_WIN; g++) begin : gWin
      logic [31:0] next_base;
      logic [31:0] next_mask;
      logic [31:0] next_offset;
      logic        next_enable;
      always_comb begin
        next_base   = base[g];
        next_mask   = mask[g];
        next_offset = offset[g];
        next_enable = enable[g];
        if (wrEn && (wrIdx == 2'(g))) begin
          next_base   = wrBase;
          next_mask   = wrMask;
          next_offset = wrOffset;
          next_enable = wrEnable;
        end
      end
      // Reset clears every window so nothing decodes until programmed
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          base[g]   <= rdad_pkg::WIN_RST_VAL;
          mask[g]   <= rdad_pkg::WIN_RST_VAL;
          offset[g] <= rdad_pkg::WIN_RST_VAL;
          enable[g] <= 1'b0;
        end else begin
          base[g]   <= next_base;
          mask[g]   <= next_mask;
          offset[g] <= next_offset;
          enable[g] <= next_enable;
        end
      end
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          rdBase[32*g +: 32]   <= rdad_pkg::WIN_RST_VAL;
          rdMask[32*g +: 32]   <= rdad_pkg::WIN_RST_VAL;
          rdOffset[32*g +: 32] <= rdad_pkg::WIN_RST_VAL;
          rdEnable[g]          <= 1'b0;
        end else begin
          rdBase[32*g +: 32]   <= base[g];
          rdMask[32*g +: 32]   <= mask[g];
          rdOffset[32*g +: 32] <= offset[g];
          rdEnable[g]          <= enable[g];
        end
      end
    end
  endgenerate

endmodule : rdad_win_table

// ---- rdad_decoder_props.sv ----
// Checker on the decoder top ports.
// Assumes one clock, core_clk, and nrst active low.
`timescale 1ns/1ns
module rdad_decoder_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // Processor side
  input wire logic        cpuValid,
  input wire logic [31:0] cpuAddr,
  input wire logic        boot_bank_swap,
  input wire logic        mapProgram,
  input wire logic [3:0]  tgtSel,
  input wire logic        bootBankB,
  input wire logic [31:0] tgtOffset,
  input wire logic        cpuUnmapped,
  input wire logic        mapDefault,
  // Window tables and outbound path
  input wire logic        pciWrEn,
  input wire logic [3:0]  pciHit,
  input wire logic        vmeInWrEn,
  input wire logic [3:0]  vmeInHit,
  input wire logic        vmeOutWrEn,
  input wire logic [31:0] vmeOutWrOffset,
  input wire logic        vmeOutValid,
  input wire logic [31:0] vmeOutAddr,
  input wire logic        vmeOutValidQ,
  input wire logic [31:0] vmeOutBusAddr
);
  // ====================================
  // Helper state
  logic        pciTouched;
  logic        vmeTouched;
  logic [31:0] offQ;
  logic        dflt;
  logic        isIo;
  logic        isMc;
  logic        isBr;
  logic        isBoot;
  assign dflt   = cpuValid && mapDefault;
  assign isIo   = cpuAddr[31:17] == 15'h4000;
  assign isMc   = cpuAddr[31:16] == 16'hFEF8;
  assign isBr   = cpuAddr[31:16] == 16'hFEFF;
  assign isBoot = cpuAddr[31:20] == 12'hFFF;
  // Tracks whether software touched a table since reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pciTouched <= 1'b0;
      vmeTouched <= 1'b0;
      offQ       <= 32'h0000_0000;
    end else begin
      pciTouched <= pciTouched | pciWrEn;
      vmeTouched <= vmeTouched | vmeInWrEn;
      offQ       <= vmeOutWrEn ? vmeOutWrOffset : offQ;
    end
  end
  // ====================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_io_route: assert property (dflt && isIo |=>
    tgtSel == rdad_pkg::TGT_PCIIO && !cpuUnmapped)
    else $error("io window not selected");
  chk_mc_route: assert property (dflt && isMc |=>
    tgtSel == rdad_pkg::TGT_MCREG
    && tgtOffset == ($past(cpuAddr) & 32'h0000_FFFF))
    else $error("mem ctl window wrong");
  chk_br_route: assert property (dflt && isBr |=>
    tgtSel == rdad_pkg::TGT_BRREG
    && tgtOffset == ($past(cpuAddr) & 32'h0000_FFFF))
    else $error("bridge window wrong");
  chk_boot_bank: assert property (dflt && isBoot |=>
    tgtSel == rdad_pkg::TGT_BOOT && bootBankB == $past(boot_bank_swap)
    && tgtOffset == ($past(cpuAddr) & 32'h000F_FFFF))
    else $error("boot window wrong");
  chk_gap_none: assert property (
    dflt && !(isIo || isMc || isBr || isBoot)
    |=> tgtSel == rdad_pkg::TGT_NONE && cpuUnmapped)
    else $error("gap selected a target");
  chk_map_hold: assert property (mapDefault && !mapProgram |=>
    mapDefault)
    else $error("default map dropped");
  chk_pci_off: assert property (!pciTouched |-> pciHit == 4'h0)
    else $error("pci window hit before programming");
  chk_vme_off: assert property (!vmeTouched |-> vmeInHit == 4'h0)
    else $error("vme window hit before programming");
  chk_out_xlate: assert property (vmeOutValid |=> vmeOutValidQ
    && vmeOutBusAddr == $past(vmeOutAddr) + $past(offQ))
    else $error("outbound address wrong");
endmodule : rdad_decoder_props

bind rdad_decoder rdad_decoder_props u_props (
  .core_clk(core_clk), .nrst(nrst), .cpuValid(cpuValid),
  .cpuAddr(cpuAddr), .boot_bank_swap(boot_bank_swap),
  .mapProgram(mapProgram), .tgtSel(tgtSel), .bootBankB(bootBankB),
  .tgtOffset(tgtOffset), .cpuUnmapped(cpuUnmapped),
  .mapDefault(mapDefault), .pciWrEn(pciWrEn), .pciHit(pciHit),
  .vmeInWrEn(vmeInWrEn), .vmeInHit(vmeInHit), .vmeOutWrEn(vmeOutWrEn),
  .vmeOutWrOffset(vmeOutWrOffset), .vmeOutValid(vmeOutValid),
  .vmeOutAddr(vmeOutAddr), .vmeOutValidQ(vmeOutValidQ),
  .vmeOutBusAddr(vmeOutBusAddr));

// ---- rdad_cpu_master.sv ----
// Processor bus master model issuing address cycles.
// Assumes the bench requests a cycle through go and goAddr.
`timescale 1ns/1ns
module rdad_cpu_master (
  // Clock
  input  wire logic        core_clk,
  // Request from the bench
  input  wire logic        go,
  input  wire logic [31:0] goAddr,
  // Processor bus
  output logic             cpuValid,
  output logic [31:0]      cpuAddr
);
  logic [31:0] lastAddr = 32'h0000_0000;
  // Idle bus toggles, so a stale address never looks valid
  always_ff @(posedge core_clk) lastAddr <= cpuAddr;
  assign cpuValid = go;
  assign cpuAddr  = go ? goAddr : ~lastAddr;
endmodule : rdad_cpu_master

// ---- reset_default_address_decoder_tb.sv ----
// Self-checking bench for the reset default address decoder.
// Assumes inputs change on falling edges; design samples rising edges.
`timescale 1ns/1ns
module reset_default_address_decoder_tb;
  // ====================================
  // Stimulus and observation
  logic        core_clk = 1'b0, nrst = 1'b0, go = 1'b0, bankSwap = 1'b0;
  logic        mapProgram = 1'b0, mapLoad = 1'b0;
  logic [3:0]  mapTarget = 4'h0;
  logic [31:0] goAddr = 32'h0, mapBase = 32'h0, mapMask = 32'h0;
  logic        pciWrEn = 1'b0, vmeInWrEn = 1'b0, wrEnable = 1'b0;
  logic        pciValid = 1'b0, vmeInValid = 1'b0;
  logic [1:0]  wrIdx = 2'h0;
  logic [31:0] wrBase = 32'h0, wrMask = 32'h0, wrOffset = 32'h0;
  logic [31:0] lookAddr = 32'h0, vmeOutWrOffset = 32'h0, vmeOutAddr = 32'h0;
  logic        vmeOutWrEn = 1'b0, vmeOutValid = 1'b0;
  logic        cpuValid, bootBankB, cpuUnmapped, mapDefault, vmeOutValidQ;
  logic [31:0] cpuAddr, tgtOffset, pciLocalAddr, vmeInLocalAddr;
  logic [31:0] vmeOutBusAddr;
  logic [3:0]  tgtSel, pciHit, vmeInHit;
  int          badCount = 0;
  int          checksDone = 0;

  always #5 core_clk = ~core_clk;

  rdad_cpu_master u_cpu (.core_clk(core_clk), .go(go), .goAddr(goAddr),
    .cpuValid(cpuValid), .cpuAddr(cpuAddr));

  rdad_decoder u_dut (.core_clk(core_clk), .nrst(nrst),
    .cpuValid(cpuValid), .cpuAddr(cpuAddr), .boot_bank_swap(bankSwap),
    .mapProgram(mapProgram), .mapLoad(mapLoad), .mapTarget(mapTarget),
    .mapBase(mapBase), .mapMask(mapMask), .pciWrEn(pciWrEn),
    .pciWrIdx(wrIdx), .pciWrBase(wrBase), .pciWrMask(wrMask),
    .pciWrOffset(wrOffset), .pciWrEnable(wrEnable), .pciValid(pciValid),
    .pciAddr(lookAddr), .vmeInWrEn(vmeInWrEn), .vmeInWrIdx(wrIdx),
    .vmeInWrBase(wrBase), .vmeInWrMask(wrMask), .vmeInWrOffset(wrOffset),
    .vmeInWrEnable(wrEnable), .vmeInValid(vmeInValid),
    .vmeInAddr(lookAddr), .vmeOutWrEn(vmeOutWrEn),
    .vmeOutWrOffset(vmeOutWrOffset), .vmeOutValid(vmeOutValid),
    .vmeOutAddr(vmeOutAddr), .tgtSel(tgtSel), .bootBankB(bootBankB),
    .tgtOffset(tgtOffset), .cpuUnmapped(cpuUnmapped),
    .mapDefault(mapDefault), .pciHit(pciHit), .pciLocalAddr(pciLocalAddr),
    .vmeInHit(vmeInHit), .vmeInLocalAddr(vmeInLocalAddr),
    .vmeOutValidQ(vmeOutValidQ), .vmeOutBusAddr(vmeOutBusAddr));

  // ====================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] exp, got);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic testDone;
    if (badCount == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : testDone

  task automatic doReset;
    @(negedge core_clk) nrst = 1'b0;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
  endtask : doReset

  // One address cycle; results are settled at the next falling edge
  task automatic decode(input logic [31:0] a, input logic s);
    @(negedge core_clk);
    go = 1'b1;
    goAddr = a;
    bankSwap = s;
    @(negedge core_clk) go = 1'b0;
  endtask : decode

  task automatic lookup(input logic [31:0] a, input logic [3:0] hit);
    @(negedge core_clk);
    pciValid = 1'b1;
    vmeInValid = 1'b1;
    lookAddr = a;
    @(negedge core_clk);
    pciValid = 1'b0;
    vmeInValid = 1'b0;
    check("pciHit", {28'h0, hit}, {28'h0, pciHit});
    check("vmeInHit", {28'h0, hit}, {28'h0, vmeInHit});
    if (hit != 4'h0) begin
      check("pciLocal", a + 32'h100, pciLocalAddr);
      check("vmeInLocal", a + 32'h100, vmeInLocalAddr);
    end
  endtask : lookup

  // ====================================
  // Scenarios
  task automatic scnResetState;
    check("mapDefault", 32'h1, {31'h0, mapDefault});
    lookup(32'h1000_0004, 4'h0);
  endtask : scnResetState

  task automatic scnDefaultMap;
    logic [31:0] ad [16] = '{32'h0, 32'h7FFF_FFFF, 32'h8000_0000,
      32'h8001_FFFF, 32'h8002_0000, 32'hFEF7_FFFF, 32'hFEF8_0000,
      32'hFEF8_FFFF, 32'hFEF9_0000, 32'hFEFE_FFFF, 32'hFEFF_0000,
      32'hFEFF_FFFF, 32'hFF00_0000, 32'hFFEF_FFFF, 32'hFFF0_0000,
      32'hFFFF_FFFF};
    logic [3:0] tg [16] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h0, 4'h0, 4'h2,
      4'h2, 4'h0, 4'h0, 4'h4, 4'h4, 4'h0, 4'h0, 4'h8, 4'h8};
    for (int i = 0; i <= 16; i++) begin
      @(negedge core_clk);
      if (i > 0) begin
        check("tgtSel", {28'h0, tg[i-1]}, {28'h0, tgtSel});
        check("unmapped", {31'h0, tg[i-1] == 4'h0},
          {31'h0, cpuUnmapped});
      end
      go = (i < 16);
      goAddr = ad[i % 16];
    end
  endtask : scnDefaultMap

  task automatic scnBootSwap;
    for (int s = 0; s < 2; s++) begin
      decode(32'hFFF1_2345, s[0]);
      check("boot sel", 32'h8, {28'h0, tgtSel});
      check("bankB", s, {31'h0, bootBankB});
      check("boot ofs", 32'h0001_2345, tgtOffset);
    end
  endtask : scnBootSwap

  task automatic scnWindows;
    @(negedge core_clk);
    pciWrEn = 1'b1;
    vmeInWrEn = 1'b1;
    wrBase = 32'h1000_0000;
    wrMask = 32'hF000_0000;
    wrOffset = 32'h0000_0100;
    @(negedge core_clk);
    wrIdx = 2'h3;
    wrEnable = 1'b1;
    @(negedge core_clk);
    pciWrEn = 1'b0;
    vmeInWrEn = 1'b0;
    // Disabled slot 0 must lose to enabled slot 3
    lookup(32'h1000_0004, 4'h8);
    lookup(32'h2000_0000, 4'h0);
  endtask : scnWindows

  task automatic scnOutbound;
    @(negedge core_clk);
    vmeOutWrEn = 1'b1;
    vmeOutWrOffset = 32'hFFFF_FFF0;
    @(negedge core_clk);
    vmeOutWrEn = 1'b0;
    vmeOutValid = 1'b1;
    vmeOutAddr = 32'h0000_0020;
    @(negedge core_clk) vmeOutValid = 1'b0;
    check("outValid", 32'h1, {31'h0, vmeOutValidQ});
    check("outAddr", 32'h0000_0010, vmeOutBusAddr);
  endtask : scnOutbound

  task automatic scnReprogram;
    @(negedge core_clk);
    mapLoad = 1'b1;
    mapTarget = rdad_pkg::TGT_MCREG;
    mapBase = 32'h1234_0000;
    mapMask = 32'hFFFF_0000;
    @(negedge core_clk);
    mapLoad = 1'b0;
    mapProgram = 1'b1;
    @(negedge core_clk) mapProgram = 1'b0;
    check("mapDefault", 32'h0, {31'h0, mapDefault});
    decode(32'h1234_0010, 1'b0);
    check("prog sel", 32'h2, {28'h0, tgtSel});
    doReset();
    check("mapDefault", 32'h1, {31'h0, mapDefault});
    decode(32'h1234_0010, 1'b0);
    check("reset sel", 32'h0, {28'h0, tgtSel});
    lookup(32'h1000_0004, 4'h0);
  endtask : scnReprogram

  // ====================================
  // Main sequence and hang guard
  initial begin
    doReset();
    scnResetState();
    scnDefaultMap();
    scnBootSwap();
    scnWindows();
    scnOutbound();
    scnReprogram();
    testDone();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    badCount++;
    testDone();
  end
endmodule : reset_default_address_decoder_tb
